/* common/tmc_pkg.sv */
// package for the texture mapping control block: register map, fields, resets, carriers
// assumes a single 10 MHz core clock and a synchronous active-low reset
package tmc_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] TMC_ADDR_CHIPSEL = 8'h00;
	localparam logic [7:0] TMC_ADDR_MODE    = 8'h04;
	localparam logic [7:0] TMC_ADDR_LOD     = 8'h08;
	localparam logic [7:0] TMC_ADDR_BASE0   = 8'h10;
	localparam logic [7:0] TMC_ADDR_NCC0    = 8'h20;
	localparam int         TMC_NUM_BASE     = 4;
	localparam int         TMC_NUM_NCC      = 8;
	localparam int         TMC_NCC_PER_TBL  = 4;

	// ----------------------------------------------------------------
	// reset values and write masks
	// ----------------------------------------------------------------
	localparam logic [1:0]  TMC_RST_CHIPSEL = 2'h0;
	localparam logic [31:0] TMC_RST_MODE    = 32'h0000_0000;
	localparam logic [31:0] TMC_RST_LOD     = 32'h0000_0000;
	localparam logic [31:0] TMC_MODE_MASK   = 32'h7fff_ffff;
	localparam logic [31:0] TMC_LOD_MASK    = 32'h0fff_ffff;

	// ----------------------------------------------------------------
	// texture mode fields
	// ----------------------------------------------------------------
	localparam int TMC_M_PERSP   = 0;
	localparam int TMC_M_MINF    = 1;
	localparam int TMC_M_MAGF    = 2;
	localparam int TMC_M_CLAMPW  = 3;
	localparam int TMC_M_DITHER  = 4;
	localparam int TMC_M_NCCSEL  = 5;
	localparam int TMC_M_CLAMPS  = 6;
	localparam int TMC_M_CLAMPT  = 7;
	localparam int TMC_M_FMT_LO  = 8;
	localparam int TMC_M_TC_LO   = 12;
	localparam int TMC_M_TCA_LO  = 21;
	localparam int TMC_M_TRILIN  = 30;

	// ----------------------------------------------------------------
	// level of detail fields
	// ----------------------------------------------------------------
	localparam int TMC_L_MIN_LO   = 0;
	localparam int TMC_L_MAX_LO   = 6;
	localparam int TMC_L_BIAS_LO  = 12;
	localparam int TMC_L_ODD      = 18;
	localparam int TMC_L_SPLIT    = 19;
	localparam int TMC_L_SWIDER   = 20;
	localparam int TMC_L_ASP_LO   = 21;
	localparam int TMC_L_ZFRAC    = 23;
	localparam int TMC_L_MULTI    = 24;
	localparam int TMC_L_SWIZZLE  = 25;
	localparam int TMC_L_SWAP     = 26;
	localparam int TMC_L_DIRECT   = 27;
	localparam logic [7:0] TMC_LOD_CEIL = 8'h20;  // 8.0 in 4.2
	localparam logic [7:0] TMC_ALPHA_FF = 8'hff;

	// ----------------------------------------------------------------
	// texel formats and combine mux selects
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TMC_F_RGB332 = 4'h0, TMC_F_YIQ = 4'h1, TMC_F_A8 = 4'h2, TMC_F_I8 = 4'h3,
		TMC_F_AI44 = 4'h4, TMC_F_ARGB8332 = 4'h8, TMC_F_AYIQ = 4'h9,
		TMC_F_RGB565 = 4'ha, TMC_F_ARGB1555 = 4'hb, TMC_F_ARGB4444 = 4'hc,
		TMC_F_AI88 = 4'hd
	} tmc_fmt_e;

	typedef enum logic [2:0] {
		TMC_MX_ZERO = 3'h0, TMC_MX_CLOCAL = 3'h1, TMC_MX_AOTHER = 3'h2,
		TMC_MX_ALOCAL = 3'h3, TMC_MX_LOD = 3'h4, TMC_MX_LODFRAC = 3'h5
	} tmc_mux_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              valid;
		logic signed [15:0] s;
		logic signed [15:0] t;
		logic signed [15:0] w;
		logic signed [7:0]  lod;       // computed lod, 6.2
		logic [3:0]         size_log2; // log2 of the wider dimension
		logic [15:0]        texel;
		logic [31:0]        other;     // incoming argb
	} tmc_pix_in_s;

	typedef struct packed {
		logic        valid;
		logic [15:0] s;
		logic [15:0] t;
		logic [5:0]  lod;
		logic        bilinear;
		logic        trilinear;
		logic [2:0]  level_base_index;
		logic [18:0] base;
		logic [31:0] texel_argb;
		logic [31:0] comb_argb;
	} tmc_pix_out_s;

	typedef struct packed {
		logic        valid;
		logic [18:0] addr;
		logic [31:0] data;
	} tmc_wr_in_s;

	typedef struct packed {
		logic        valid;
		logic [1:0]  chip;
		logic [3:0]  format;
		logic        direct;
		logic [18:0] addr;
		logic [31:0] data;
	} tmc_wr_out_s;

endpackage

/* rtl/tmc_texture_mapping_control.sv */
// texture mapping control: registers over ahb-lite, pixel and texture-write paths
// assumes one 10 MHz clock, synchronous active-low reset, one ahb master
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

module tmc_texture_mapping_control (
	input  wire  logic                  mclk,
	input  wire  logic                  rst_n,
	input  wire  logic                  hsel,
	input  wire  logic [31:0]           haddr,
	input  wire  logic [1:0]            htrans,
	input  wire  logic                  hwrite,
	input  wire  logic [2:0]            hsize,
	input  wire  logic                  hready,
	input  wire  logic [31:0]           hwdata,
	output logic       [31:0]           hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	input  wire  tmc_pkg::tmc_pix_in_s  pix_in,
	output tmc_pkg::tmc_pix_out_s       pix_out,
	input  wire  tmc_pkg::tmc_wr_in_s   wr_in,
	output tmc_pkg::tmc_wr_out_s        wr_out
);
	import tmc_pkg::*;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [1:0]  chipsel_q;
	logic [31:0] mode_q;
	logic [31:0] lod_q;
	logic [18:0] base_q [TMC_NUM_BASE];
	logic [23:0] ncc_q  [TMC_NUM_NCC];
	logic        dph_wr_q;
	logic [7:0]  dph_addr_q;
	logic [1:0]  dither_q;

	// ----------------------------------------------------------------
	// ahb-lite slave, zero wait states, always okay
	// ----------------------------------------------------------------
	logic       aph_take;
	logic [31:0] rd_d;

	assign aph_take = hsel && hready && htrans[1];

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dph_wr_q   <= 1'b0;
			dph_addr_q <= 8'h00;
		end else if (hready) begin
			dph_wr_q   <= aph_take && hwrite;
			dph_addr_q <= haddr[7:0];
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		case (haddr[7:0])
			TMC_ADDR_CHIPSEL: rd_d = {30'h0000_0000, chipsel_q};
			TMC_ADDR_MODE:    rd_d = mode_q;
			TMC_ADDR_LOD:     rd_d = lod_q;
			default: begin
				for (int i = 0; i < TMC_NUM_BASE; i++) begin
					if (haddr[7:0] == TMC_ADDR_BASE0 + 8'(4 * i))
						rd_d = {13'h0000, base_q[i]};
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (aph_take && !hwrite)
				hrdata <= rd_d;
		end
	end

	// values take hold at the data-phase edge, seen by the next pixel
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			chipsel_q <= TMC_RST_CHIPSEL;
			mode_q    <= TMC_RST_MODE;
			lod_q     <= TMC_RST_LOD;
		end else if (dph_wr_q) begin
			if (dph_addr_q == TMC_ADDR_CHIPSEL && hwdata[1:0] != 2'h3)
				chipsel_q <= hwdata[1:0];
			if (dph_addr_q == TMC_ADDR_MODE)
				mode_q <= hwdata & TMC_MODE_MASK;
			if (dph_addr_q == TMC_ADDR_LOD)
				lod_q <= hwdata & TMC_LOD_MASK;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < TMC_NUM_BASE; gi++) begin : g_base
			always_ff @(posedge mclk) begin
				if (!rst_n)
					base_q[gi] <= 19'h0_0000;
				else if (dph_wr_q && dph_addr_q == TMC_ADDR_BASE0 + 8'(4 * gi))
					base_q[gi] <= hwdata[18:0];
			end
		end
		for (gi = 0; gi < TMC_NUM_NCC; gi++) begin : g_ncc
			always_ff @(posedge mclk) begin
				if (!rst_n)
					ncc_q[gi] <= 24'h00_0000;
				else if (dph_wr_q && dph_addr_q == TMC_ADDR_NCC0 + 8'(4 * gi))
					ncc_q[gi] <= hwdata[23:0];
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	logic [3:0] fmt;
	logic [5:0] lodmin, lodmax;
	logic signed [7:0] bias;
	logic [1:0] aspect;

	assign fmt    = mode_q[TMC_M_FMT_LO +: 4];
	assign lodmin = lod_q[TMC_L_MIN_LO +: 6];
	assign lodmax = lod_q[TMC_L_MAX_LO +: 6];
	assign bias   = 8'(signed'(lod_q[TMC_L_BIAS_LO +: 6]));
	assign aspect = lod_q[TMC_L_ASP_LO +: 2];

	// ----------------------------------------------------------------
	// texel expansion to argb
	// ----------------------------------------------------------------
	function automatic logic [31:0] expand(input logic [3:0] f, input logic [15:0] x,
			input logic [23:0] ncc);
		logic [7:0] a8;
		expand = 32'h0000_0000;
		a8 = x[15:8];
		case (f)
			TMC_F_RGB332: expand = {TMC_ALPHA_FF, x[7:5], x[7:5], x[7:6],
				x[4:2], x[4:2], x[4:3], {4{x[1:0]}}};
			TMC_F_A8:     expand = {4{x[7:0]}};
			TMC_F_I8:     expand = {TMC_ALPHA_FF, {3{x[7:0]}}};
			TMC_F_AI44:   expand = {x[7:4], x[7:4], {3{x[3:0], x[3:0]}}};
			TMC_F_YIQ:    expand = {TMC_ALPHA_FF, ncc};
			TMC_F_AYIQ:   expand = {a8, ncc};
			TMC_F_ARGB8332: expand = {a8, x[7:5], x[7:5], x[7:6],
				x[4:2], x[4:2], x[4:3], {4{x[1:0]}}};
			TMC_F_RGB565: expand = {TMC_ALPHA_FF, x[15:11], x[15:13],
				x[10:5], x[10:9], x[4:0], x[4:2]};
			TMC_F_ARGB1555: expand = {{8{x[15]}}, x[14:10], x[14:12],
				x[9:5], x[9:7], x[4:0], x[4:2]};
			TMC_F_ARGB4444: expand = {x[15:12], x[15:12], x[11:8], x[11:8],
				x[7:4], x[7:4], x[3:0], x[3:0]};
			TMC_F_AI88:   expand = {a8, {3{x[7:0]}}};
			default:      expand = 32'h0000_0000;
		endcase
	endfunction

	logic [2:0]  ncc_idx;
	logic [31:0] texel_argb;

	// table select picks the upper or lower half of the lookup storage
	assign ncc_idx    = {mode_q[TMC_M_NCCSEL], pix_in.texel[7:6]};
	assign texel_argb = expand(fmt, pix_in.texel, ncc_q[ncc_idx]);

	// ----------------------------------------------------------------
	// coordinates: perspective, w clamp, clamp or wrap
	// ----------------------------------------------------------------
	logic signed [15:0] s_p, t_p;
	logic [3:0] wlog, hlog;
	logic [15:0] s_c, t_c;

	always_comb begin
		s_p = pix_in.s;
		t_p = pix_in.t;
		if (mode_q[TMC_M_PERSP] && pix_in.w != 16'sh0000) begin
			s_p = pix_in.s / pix_in.w;
			t_p = pix_in.t / pix_in.w;
		end
		if (mode_q[TMC_M_CLAMPW] && pix_in.w < 0) begin
			s_p = 16'sh0000;
			t_p = 16'sh0000;
		end
	end

	// narrower side is 2^aspect smaller; s-wider flag ignored when square
	assign wlog = (lod_q[TMC_L_SWIDER] || aspect == 2'b00) ? pix_in.size_log2 :
		pix_in.size_log2 - {2'b00, aspect};
	assign hlog = (!lod_q[TMC_L_SWIDER] || aspect == 2'b00) ? pix_in.size_log2 :
		pix_in.size_log2 - {2'b00, aspect};

	function automatic logic [15:0] fit(input logic signed [15:0] v, input logic [3:0] lg,
			input logic clamp);
		logic [15:0] lim;
		lim = (16'h0001 << lg) - 16'h0001;
		if (!clamp)
			fit = v & lim;
		else if (v < 0)
			fit = 16'h0000;
		else if (v > signed'(lim))
			fit = lim;
		else
			fit = v;
	endfunction

	assign s_c = fit(s_p, wlog, mode_q[TMC_M_CLAMPS]);
	assign t_c = fit(t_p, hlog, mode_q[TMC_M_CLAMPT]);

	// ----------------------------------------------------------------
	// level of detail
	// ----------------------------------------------------------------
	logic signed [9:0] lod_b;
	logic [5:0] lod_hi, lod_f;
	logic       use_min;
	logic [2:0] lvl;

	// dither pattern 0,1,2,3 quarter steps averages 0.375 of a level
	always_ff @(posedge mclk) begin
		if (!rst_n)
			dither_q <= 2'h0;
		else if (pix_in.valid)
			dither_q <= dither_q + 2'h1;
	end

	always_comb begin
		lod_b = 10'(pix_in.lod) + 10'(bias)
			+ (mode_q[TMC_M_DITHER] ? {8'h00, dither_q} : 10'h000);
		lod_hi = (lodmax > 6'(TMC_LOD_CEIL)) ? 6'(TMC_LOD_CEIL) : lodmax;
		use_min = lod_b >= signed'({4'h0, lodmin});
		if (!use_min)
			lod_f = lodmin;
		else if (lod_b > signed'({4'h0, lod_hi}))
			lod_f = lod_hi;
		else
			lod_f = lod_b[5:0];
		if (lod_q[TMC_L_ZFRAC])
			lod_f[1:0] = 2'b00;
		// split texture holds every other level, so index halves
		if (lod_q[TMC_L_SPLIT])
			lvl = 3'((lod_f[5:2] + {3'h0, lod_f[2] ^ lod_q[TMC_L_ODD]}) >> 1);
		else
			lvl = 3'(lod_f[5:2]);
	end

	// ----------------------------------------------------------------
	// combine units: colour for r,g,b and alpha unit for a
	// ----------------------------------------------------------------
	// a net, so that each combine unit drives its own byte lane
	wire  [31:0] comb;

	generate
		for (gi = 0; gi < 4; gi++) begin : g_comb
			localparam int LO = (gi == 3) ? TMC_M_TCA_LO : TMC_M_TC_LO;
			logic [8:0] c;
			logic [7:0] cl, co, fac, res;
			assign comb[8 * gi +: 8] = res;
			logic signed [17:0] diff, acc;
			always_comb begin
				c   = mode_q[LO +: 9];
				cl  = texel_argb[8 * gi +: 8];
				co  = c[0] ? 8'h00 : pix_in.other[8 * gi +: 8];
				case (tmc_mux_e'(c[4:2]))
					TMC_MX_CLOCAL:  fac = cl;
					TMC_MX_AOTHER:  fac = pix_in.other[31:24];
					TMC_MX_ALOCAL:  fac = texel_argb[31:24];
					TMC_MX_LOD:     fac = {lod_f, 2'b00};
					TMC_MX_LODFRAC: fac = {lod_f[1:0], 6'h00};
					default:        fac = 8'h00;
				endcase
				if (c[5])
					fac = ~fac;
				diff = 18'(signed'({1'b0, co})) - (c[1] ? 18'(cl) : 18'sh0_0000);
				acc  = (diff * signed'({10'h000, fac})) >>> 8;
				if (c[6])
					acc = acc + 18'(cl);
				if (c[7])
					acc = acc + 18'(texel_argb[31:24]);
				if (acc < 0)
					res = 8'h00;
				else if (acc > 18'sh0_00ff)
					res = 8'hff;
				else
					res = acc[7:0];
				if (c[8])
					res = ~res;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// pixel output stage
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pix_out <= '0;
		end else begin
			pix_out.valid      <= pix_in.valid;
			pix_out.s          <= s_c;
			pix_out.t          <= t_c;
			pix_out.lod        <= lod_f;
			pix_out.bilinear   <= use_min ? mode_q[TMC_M_MINF] : mode_q[TMC_M_MAGF];
			pix_out.trilinear  <= mode_q[TMC_M_TRILIN];
			pix_out.level_base_index <= lvl;
			if (!lod_q[TMC_L_MULTI] || lvl == 3'h0)
				pix_out.base <= base_q[0];
			else if (lvl < 3'h3)
				pix_out.base <= base_q[lvl[1:0]];
			else
				pix_out.base <= base_q[3];
			pix_out.texel_argb <= texel_argb;
			pix_out.comb_argb  <= comb;
		end
	end

	// ----------------------------------------------------------------
	// texture write path
	// ----------------------------------------------------------------
	logic [31:0] wd_swz, wd_out;

	assign wd_swz = lod_q[TMC_L_SWIZZLE] ? {wr_in.data[7:0], wr_in.data[15:8],
		wr_in.data[23:16], wr_in.data[31:24]} : wr_in.data;
	assign wd_out = lod_q[TMC_L_SWAP] ? {wd_swz[15:0], wd_swz[31:16]} : wd_swz;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_out <= '0;
		end else begin
			wr_out.valid  <= wr_in.valid;
			wr_out.chip   <= chipsel_q;
			wr_out.format <= fmt;
			wr_out.direct <= wr_in.valid && lod_q[TMC_L_DIRECT];
			wr_out.addr   <= wr_in.addr;
			wr_out.data   <= wd_out;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_chipsel_legal: assert property (@(posedge mclk) disable iff (!rst_n)
		chipsel_q != 2'h3) else $error("chip select holds an illegal value");
	chk_wclamp_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		pix_in.valid && mode_q[TMC_M_CLAMPW] && pix_in.w < 0 && !dph_wr_q
		|=> pix_out.s == 16'h0000 && pix_out.t == 16'h0000)
		else $error("negative w did not zero s and t");
	chk_lod_range: assert property (@(posedge mclk) disable iff (!rst_n)
		pix_out.valid && lodmin <= TMC_LOD_CEIL[5:0] && $stable(lod_q)
		|-> pix_out.lod >= lodmin && pix_out.lod <= TMC_LOD_CEIL[5:0])
		else $error("lod outside clamp range");
	chk_zero_frac: assert property (@(posedge mclk) disable iff (!rst_n)
		lod_q[TMC_L_ZFRAC] && !dph_wr_q |=> pix_out.lod[1:0] == 2'b00)
		else $error("lod fraction not cleared");
	chk_swap_order: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_in.valid && lod_q[TMC_L_SWIZZLE] && lod_q[TMC_L_SWAP] && !dph_wr_q
		|=> wr_out.data == {$past(wr_in.data[23:16]), $past(wr_in.data[31:24]),
			$past(wr_in.data[7:0]), $past(wr_in.data[15:8])})
		else $error("byte then halfword swap wrong");
	chk_direct_gate: assert property (@(posedge mclk) disable iff (!rst_n)
		wr_out.direct |-> wr_out.valid && lod_q[TMC_L_DIRECT] || $past(dph_wr_q))
		else $error("direct write without enable");
	chk_single_base: assert property (@(posedge mclk) disable iff (!rst_n)
		!lod_q[TMC_L_MULTI] && !dph_wr_q ##1 !dph_wr_q |-> pix_out.base == base_q[0])
		else $error("single base not used");
	chk_trilinear_bit: assert property (@(posedge mclk) disable iff (!rst_n)
		dph_wr_q && dph_addr_q == TMC_ADDR_MODE ##1 !dph_wr_q
		|=> pix_out.trilinear == $past(mode_q[TMC_M_TRILIN]))
		else $error("trilinear output does not follow mode");

endmodule // tmc_texture_mapping_control

/* testbench/tmc_texture_mapping_control_tb_top.sv */
// testbench for the texture mapping control block: ahb-lite register access, pixel and write paths
// assumes zero-wait ahb slave, one-cycle pixel and write paths, 10 MHz clock
`timescale 1ns/1ps
module tmc_texture_mapping_control_tb_top;
	import tmc_pkg::*;
	logic          mclk;
	logic          rst_n;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	tmc_pix_in_s   pix_in;
	tmc_pix_out_s  pix_out;
	tmc_wr_in_s    wr_in;
	tmc_wr_out_s   wr_out;
	tmc_pix_out_s  po;
	int            n_errors;
	int            check_count;
	logic [31:0]   rv;
	logic [31:0]   tx_exp [13] = '{32'hff6d6d55, 32'hff123456, 32'h6d6d6d6d, 32'hff6d6d6d,
		32'h66dddddd, 0, 0, 0, 32'h9c6d6d55, 32'h9cabcdef, 32'hff9c8e6b, 32'hff39186b,
		32'h99cc66dd};
	logic [31:0]   cmode [4] = '{32'h0, 32'hc0, 32'h08, 32'h01};
	logic [15:0]   cs [4] = '{16'd20, 16'd20, 16'd5, 16'd40};
	logic [15:0]   ct [4] = '{16'hffff, 16'hffff, 16'd3, 16'd20};
	logic [15:0]   cw [4] = '{16'd1, 16'd1, 16'hfffe, 16'd4};
	logic [31:0]   cexp [4] = '{{16'd4, 16'd15}, {16'd15, 16'd0}, 32'h0, {16'd10, 16'd5}};
	logic [31:0]   lreg [5] = '{32'hfc4, 32'hfc4, 32'h300, 32'h3cfc0, 32'h800fc0};
	logic [7:0]    lin [5] = '{8'h30, 8'h01, 8'h14, 8'h0a, 8'h09};
	logic [7:0]    lexp [5] = '{8'h20, 8'h04, 8'h0c, 8'h06, 8'h08};
	logic [7:0]    bl [5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h08};
	logic [31:0]   wexp [4] = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433};

	tmc_texture_mapping_control dut (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hreadyout),
		.hwdata    (hwdata),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.pix_in    (pix_in),
		.pix_out   (pix_out),
		.wr_in     (wr_in),
		.wr_out    (wr_out)
	);

	// ----------------------------------------------------------------
	// clock, shared tasks
	// ----------------------------------------------------------------
	always #50 mclk = ~mclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("errors %0d, comparisons %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) n_errors++;
	endtask

	// one single-word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsize  <= 3'b010;
		wait_rdy;
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rv = hrdata;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(rv, exp);
	endtask

	task automatic pix(input logic [15:0] s, input logic [15:0] t, input logic [15:0] w,
		input logic [7:0] lod);
		tmc_pix_in_s p;
		p = '0;
		p.valid = 1'b1;
		p.s = s;
		p.t = t;
		p.w = w;
		p.lod = lod;
		p.size_log2 = 4'h4;
		p.texel = 16'h9c6d;
		pix_in <= p;
		@(posedge mclk);
		pix_in <= '0;
		#1;
		po = pix_out;
		@(posedge mclk);
	endtask

	initial begin
		#200_000;
		n_errors++;
		give_verdict;
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 0;
		rst_n = 0;
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
		pix_in = '0;
		wr_in = '0;
		n_errors = 0;
		check_count = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd_chk(TMC_ADDR_CHIPSEL, 32'h0);
		rd_chk(TMC_ADDR_MODE, 32'h0);
		rd_chk(TMC_ADDR_LOD, 32'h0);
		check(hresp, 1'b0);
		ahb(1'b1, 8'hfc, 32'hffff_ffff);
		rd_chk(8'hfc, 32'h0);
		ahb(1'b1, TMC_ADDR_CHIPSEL, 32'h2);
		ahb(1'b1, TMC_ADDR_CHIPSEL, 32'h3);
		rd_chk(TMC_ADDR_CHIPSEL, 32'h2);
		ahb(1'b1, TMC_ADDR_MODE, 32'hffff_ffff);
		rd_chk(TMC_ADDR_MODE, 32'h7fff_ffff);
		ahb(1'b1, TMC_ADDR_LOD, 32'hffff_ffff);
		rd_chk(TMC_ADDR_LOD, 32'h0fff_ffff);
		pix(16'd0, 16'd0, 16'd1, 8'h0);
		check(po.trilinear, 1'b1);
		ahb(1'b1, TMC_ADDR_LOD, 32'h0);
		ahb(1'b1, TMC_ADDR_NCC0 + 8'h04, 32'h0012_3456);
		ahb(1'b1, TMC_ADDR_NCC0 + 8'h14, 32'h00ab_cdef);
		rd_chk(TMC_ADDR_NCC0 + 8'h04, 32'h0);
		for (int f = 0; f < 13; f++) begin
			if (f >= 5 && f <= 7) continue;
			ahb(1'b1, TMC_ADDR_MODE, (f << 8) | ((f == 9) ? 32'h20 : 32'h0));
			pix(16'd0, 16'd0, 16'd1, 8'h0);
			check(po.texel_argb, tx_exp[f]);
		end
		ahb(1'b1, TMC_ADDR_MODE, 32'h0120);
		pix(16'd0, 16'd0, 16'd1, 8'h0);
		check(po.texel_argb, 32'hffabcdef);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, TMC_ADDR_MODE, cmode[i]);
			pix(cs[i], ct[i], cw[i], 8'h0);
			check({po.s, po.t}, cexp[i]);
		end
		ahb(1'b1, TMC_ADDR_MODE, 32'h2010_0000);
		pix(16'd0, 16'd0, 16'd1, 8'h0);
		check(po.comb_argb, 32'hffff_ffff);
		ahb(1'b1, TMC_ADDR_MODE, 32'h2);
		pix(16'd0, 16'd0, 16'd1, 8'h0);
		check(po.comb_argb, 32'h0);
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, TMC_ADDR_LOD, lreg[i]);
			pix(16'd0, 16'd0, 16'd1, lin[i]);
			check(po.lod, lexp[i][5:0]);
			check(po.bilinear, (i != 1));
		end
		// four pixels cover every dither phase once: 6 quarter steps in total
		ahb(1'b1, TMC_ADDR_LOD, 32'h0000_0fc0);
		ahb(1'b1, TMC_ADDR_MODE, 32'h0000_0010);
		rv = 32'h0;
		for (int i = 0; i < 4; i++) begin
			pix(16'd0, 16'd0, 16'd1, 8'h0);
			rv = rv + 32'(po.lod);
		end
		check(rv, 32'h6);
		for (int i = 0; i < 4; i++)
			ahb(1'b1, TMC_ADDR_BASE0 + 8'(4 * i), 32'h11111 * (i + 1));
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, TMC_ADDR_LOD, (i < 4) ? 32'h0100_0fc0 : 32'h0fc0);
			pix(16'd0, 16'd0, 16'd1, bl[i]);
			check(po.base, 19'h11111 * ((i < 4) ? i + 1 : 1));
		end
		ahb(1'b1, TMC_ADDR_MODE, 32'h0c00);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b1, TMC_ADDR_LOD, (i == 3) ? 32'h0e00_0000 : (i << 25));
			wr_in <= '{valid: 1'b1, addr: 19'h12345, data: 32'h1122_3344};
			@(posedge mclk);
			wr_in <= '0;
			#1;
			check({wr_out.valid, wr_out.chip, wr_out.format, wr_out.direct},
				{1'b1, 2'h2, 4'hc, (i == 3)});
			check(wr_out.data, wexp[i]);
			@(posedge mclk);
		end
		give_verdict;
	end
endmodule // tmc_texture_mapping_control_tb_top
